// ---- shared/hcr_regs.svh ----
`ifndef HCR_REGS_SVH
`define HCR_REGS_SVH

// register byte offsets
`define HCR_OFS_VERSION     8'h00
`define HCR_OFS_ROM_PORT    8'h04
`define HCR_OFS_RETRY       8'h08
`define HCR_OFS_CS_NEW      8'h0c
`define HCR_OFS_CS_CMP      8'h10
`define HCR_OFS_CS_CTRL     8'h14

// version register fields
`define HCR_VER_MAJOR       8'h01
`define HCR_VER_MINOR       8'h10
`define HCR_VER_PRESENT_BIT 24

// serial rom access port fields
`define HCR_ROM_CLEAR_BIT   31
`define HCR_ROM_FETCH_BIT   25
`define HCR_ROM_DATA_LSB    16
`define HCR_SMALL_ROM_OFS   8'h20
`define HCR_SMALL_ROM_BYTE  8'h06
`define HCR_SMALL_ROM_FLAG  5
`define HCR_BOOT_BYTES      20

// retry register fields
`define HCR_RETRY_PHYS_LSB  8
`define HCR_RETRY_RSP_LSB   4
`define HCR_RETRY_REQ_LSB   0
`define HCR_RETRY_W         4
`define HCR_RETRY_RESET     4'h0

// compare-swap control fields
`define HCR_CS_DONE_BIT     31
`define HCR_CS_DONE_RESET   1'b1
`define HCR_CS_SEL_RESET    2'b00

`endif

// ---- shared/hcr_pkg.sv ----
package hcr_pkg;

   typedef enum logic [4:0] {
      ROM_INIT  = 5'b0_0001,
      ROM_BOOT  = 5'b0_0010,
      ROM_IDLE  = 5'b0_0100,
      ROM_FETCH = 5'b0_1000,
      ROM_CLEAR = 5'b1_0000
   } hcr_rom_state_t;

   typedef enum logic [1:0] {
      CS_BUS_MANAGER_ID = 2'b00,
      CS_BANDWIDTH_AVL  = 2'b01,
      CS_CHANNELS_HI    = 2'b10,
      CS_CHANNELS_LO    = 2'b11
   } hcr_cs_target_t;

endpackage

// ---- verilog/hcr_rom_engine.sv ----
`timescale 1ns/1ps
`include "hcr_regs.svh"

module hcr_rom_engine #(
   parameter int ADDR_W     = 8,
   parameter int BOOT_BYTES = `HCR_BOOT_BYTES
) (
   input  wire logic              ref_clk,
   input  wire logic              rst_n,
   input  wire logic              rom_detect,
   input  wire logic              clear_req,
   input  wire logic              fetch_req,
   output logic                   rom_rd_req,
   output logic [ADDR_W-1:0]      rom_rd_addr,
   input  wire logic              rom_rd_ack,
   input  wire logic [7:0]        rom_rd_data,
   output logic                   present,
   output logic                   clear_busy,
   output logic                   fetch_busy,
   output logic [7:0]             fetched_byte,
   output logic                   small_rom_flag,
   output logic                   boot_load_valid,
   output logic [ADDR_W-1:0]      boot_load_index,
   output logic [7:0]             boot_load_data
);
   import hcr_pkg::*;

   hcr_rom_state_t    state_q,   state_d;
   logic [ADDR_W-1:0] addr_q,    addr_d;
   logic              present_q, present_d;
   logic              clr_q,     clr_d;
   logic              fch_q,     fch_d;
   logic [7:0]        byte_q,    byte_d;
   logic              small_q,   small_d;
   logic              bval_q,    bval_d;
   logic [ADDR_W-1:0] bidx_q,    bidx_d;
   logic [7:0]        bdat_q,    bdat_d;

   always_comb
   begin
      state_d   = state_q;
      addr_d    = addr_q;
      present_d = present_q;
      clr_d     = clr_q | clear_req;
      fch_d     = fch_q | fetch_req;
      byte_d    = byte_q;
      small_d   = small_q;
      bval_d    = 1'b0;
      bidx_d    = bidx_q;
      bdat_d    = bdat_q;
      case (state_q)
         ROM_INIT:
         begin
            // strap caught one cycle after reset release
            present_d = rom_detect;
            addr_d    = '0;
            state_d   = rom_detect ? ROM_BOOT : ROM_IDLE;
         end
         ROM_BOOT:
         begin
            if (rom_rd_ack)
            begin
               bval_d = 1'b1;
               bidx_d = addr_q;
               bdat_d = rom_rd_data;
               if (addr_q == ADDR_W'(`HCR_SMALL_ROM_BYTE))
               begin
                  small_d = rom_rd_data[`HCR_SMALL_ROM_FLAG];
               end
               if (addr_q == ADDR_W'(BOOT_BYTES - 1))
               begin
                  addr_d  = '0;
                  state_d = ROM_IDLE;
               end
               else
               begin
                  addr_d = addr_q + ADDR_W'(1);
               end
            end
         end
         ROM_IDLE:
         begin
            // address clear served before a fetch written alongside it
            if (clr_q)
            begin
               state_d = ROM_CLEAR;
            end
            else if (fch_q && present_q)
            begin
               state_d = ROM_FETCH;
            end
            else if (fch_q)
            begin
               // no device: finish without touching the held byte
               fch_d = fetch_req;
            end
         end
         ROM_FETCH:
         begin
            if (rom_rd_ack)
            begin
               byte_d  = rom_rd_data;
               addr_d  = addr_q + ADDR_W'(1);
               fch_d   = fetch_req;
               state_d = ROM_IDLE;
            end
         end
         ROM_CLEAR:
         begin
            addr_d  = '0;
            clr_d   = clear_req;
            state_d = ROM_IDLE;
         end
         default:
         begin
            state_d = ROM_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         state_q   <= ROM_INIT;
         addr_q    <= '0;
         present_q <= 1'b0;
         clr_q     <= 1'b0;
         fch_q     <= 1'b0;
         byte_q    <= 8'h00;
         small_q   <= 1'b0;
         bval_q    <= 1'b0;
         bidx_q    <= '0;
         bdat_q    <= 8'h00;
      end
      else
      begin
         state_q   <= state_d;
         addr_q    <= addr_d;
         present_q <= present_d;
         clr_q     <= clr_d;
         fch_q     <= fch_d;
         byte_q    <= byte_d;
         small_q   <= small_d;
         bval_q    <= bval_d;
         bidx_q    <= bidx_d;
         bdat_q    <= bdat_d;
      end
   end

   assign rom_rd_req      = (state_q == ROM_BOOT) || (state_q == ROM_FETCH);
   assign rom_rd_addr     = addr_q;
   assign present         = present_q;
   assign clear_busy      = clr_q;
   assign fetch_busy      = fch_q;
   assign fetched_byte    = byte_q;
   assign small_rom_flag  = small_q;
   assign boot_load_valid = bval_q;
   assign boot_load_index = bidx_q;
   assign boot_load_data  = bdat_q;

endmodule

// ---- verilog/hcr_cswap.sv ----
`timescale 1ns/1ps
`include "hcr_regs.svh"

module hcr_cswap (
   input  wire logic                    ref_clk,
   input  wire logic                    rst_n,
   input  wire logic                    ctrl_wr,
   input  wire hcr_pkg::hcr_cs_target_t ctrl_target,
   input  wire logic                    values_load,
   input  wire logic [31:0]             new_value_in,
   input  wire logic [31:0]             cmp_value_in,
   input  wire logic                    swap_finished,
   output logic                         swap_start,
   output hcr_pkg::hcr_cs_target_t      swap_target,
   output logic                         swap_complete,
   output logic [31:0]                  new_value,
   output logic [31:0]                  cmp_value
);
   import hcr_pkg::*;

   logic           done_q,  done_d;
   hcr_cs_target_t sel_q,   sel_d;
   logic           start_q, start_d;
   logic [31:0]    new_q,   new_d;
   logic [31:0]    cmp_q,   cmp_d;

   always_comb
   begin
      done_d  = done_q;
      sel_d   = sel_q;
      start_d = 1'b0;
      new_d   = new_q;
      cmp_d   = cmp_q;
      if (ctrl_wr)
      begin
         done_d  = 1'b0;
         sel_d   = ctrl_target;
         start_d = 1'b1;
      end
      // completion wins over a clearing write in the same cycle
      if (swap_finished)
      begin
         done_d = 1'b1;
      end
      if (values_load)
      begin
         new_d = new_value_in;
         cmp_d = cmp_value_in;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         done_q  <= `HCR_CS_DONE_RESET;
         sel_q   <= hcr_cs_target_t'(`HCR_CS_SEL_RESET);
         start_q <= 1'b0;
      end
      else
      begin
         done_q  <= done_d;
         sel_q   <= sel_d;
         start_q <= start_d;
      end
   end

   // value words have no reset: their content is undefined until loaded
   always_ff @(posedge ref_clk)
   begin
      new_q <= new_d;
      cmp_q <= cmp_d;
   end

   assign swap_start    = start_q;
   assign swap_target   = sel_q;
   assign swap_complete = done_q;
   assign new_value     = new_q;
   assign cmp_value     = cmp_q;

endmodule

// ---- verilog/hcr_regs.sv ----
`timescale 1ns/1ps
`include "hcr_regs.svh"

module hcr_regs #(
   parameter int ADDR_W     = 8,
   parameter int BOOT_BYTES = `HCR_BOOT_BYTES
) (
   input  wire logic                    ref_clk,
   input  wire logic                    rst_n,
   input  wire logic [7:0]              reg_addr,
   input  wire logic                    reg_wr,
   input  wire logic                    reg_rd,
   input  wire logic [31:0]             reg_wdata,
   output logic [31:0]                  reg_rdata,
   output logic                         reg_rvalid,
   input  wire logic                    rom_detect,
   output logic                         rom_rd_req,
   output logic [ADDR_W-1:0]            rom_rd_addr,
   input  wire logic                    rom_rd_ack,
   input  wire logic [7:0]              rom_rd_data,
   output logic                         boot_load_valid,
   output logic [ADDR_W-1:0]            boot_load_index,
   output logic [7:0]                   boot_load_data,
   output logic [3:0]                   phys_response_retry_count,
   output logic [3:0]                   async_response_retry_count,
   output logic [3:0]                   async_request_retry_count,
   input  wire logic                    cs_values_load,
   input  wire logic [31:0]             cs_new_value_in,
   input  wire logic [31:0]             cs_cmp_value_in,
   input  wire logic                    cs_finished,
   output logic                         cs_start,
   output hcr_pkg::hcr_cs_target_t      compare_swap_target
);
   import hcr_pkg::*;

   logic                     wr_rom;
   logic                     wr_retry;
   logic                     wr_cs_ctrl;
   logic                     eeprom_present_flag;
   logic                     rom_address_clear;
   logic                     rom_byte_fetch_go;
   logic [7:0]               rom_fetched_byte;
   logic                     small_flag;
   logic [7:0]               small_rom_offset;
   logic                     compare_swap_complete;
   logic [31:0]              cs_new_value;
   logic [31:0]              cs_cmp_value;
   logic [`HCR_RETRY_W-1:0]  phys_q, phys_d;
   logic [`HCR_RETRY_W-1:0]  rsp_q,  rsp_d;
   logic [`HCR_RETRY_W-1:0]  req_q,  req_d;
   logic [31:0]              rdata_q, rdata_d;
   logic                     rvalid_q, rvalid_d;

   // read-only offsets ignore writes
   // write strobes per register; other offsets take no write
   always_comb
   begin
      wr_rom     = 1'b0;
      wr_retry   = 1'b0;
      wr_cs_ctrl = 1'b0;
      if (reg_wr && reg_addr == `HCR_OFS_ROM_PORT)
      begin
         wr_rom = 1'b1;
      end
      else if (reg_wr && reg_addr == `HCR_OFS_RETRY)
      begin
         wr_retry = 1'b1;
      end
      else if (reg_wr && reg_addr == `HCR_OFS_CS_CTRL)
      begin
         wr_cs_ctrl = 1'b1;
      end
   end

   hcr_rom_engine #(
      .ADDR_W     (ADDR_W),
      .BOOT_BYTES (BOOT_BYTES)
   ) u_rom (
      .ref_clk         (ref_clk),
      .rst_n           (rst_n),
      .rom_detect      (rom_detect),
      .clear_req       (wr_rom && reg_wdata[`HCR_ROM_CLEAR_BIT]),
      .fetch_req       (wr_rom && reg_wdata[`HCR_ROM_FETCH_BIT]),
      .rom_rd_req      (rom_rd_req),
      .rom_rd_addr     (rom_rd_addr),
      .rom_rd_ack      (rom_rd_ack),
      .rom_rd_data     (rom_rd_data),
      .present         (eeprom_present_flag),
      .clear_busy      (rom_address_clear),
      .fetch_busy      (rom_byte_fetch_go),
      .fetched_byte    (rom_fetched_byte),
      .small_rom_flag  (small_flag),
      .boot_load_valid (boot_load_valid),
      .boot_load_index (boot_load_index),
      .boot_load_data  (boot_load_data)
   );

   hcr_cswap u_cswap (
      .ref_clk       (ref_clk),
      .rst_n         (rst_n),
      .ctrl_wr       (wr_cs_ctrl),
      .ctrl_target   (hcr_cs_target_t'(reg_wdata[1:0])),
      .values_load   (cs_values_load),
      .new_value_in  (cs_new_value_in),
      .cmp_value_in  (cs_cmp_value_in),
      .swap_finished (cs_finished),
      .swap_start    (cs_start),
      .swap_target   (compare_swap_target),
      .swap_complete (compare_swap_complete),
      .new_value     (cs_new_value),
      .cmp_value     (cs_cmp_value)
   );

   assign small_rom_offset = small_flag ? `HCR_SMALL_ROM_OFS : 8'h00;

   always_comb
   begin
      phys_d = phys_q;
      rsp_d  = rsp_q;
      req_d  = req_q;
      if (wr_retry)
      begin
         phys_d = reg_wdata[`HCR_RETRY_PHYS_LSB +: `HCR_RETRY_W];
         rsp_d  = reg_wdata[`HCR_RETRY_RSP_LSB +: `HCR_RETRY_W];
         req_d  = reg_wdata[`HCR_RETRY_REQ_LSB +: `HCR_RETRY_W];
      end
   end

   always_comb
   begin
      rdata_d  = rdata_q;
      rvalid_d = reg_rd;
      if (reg_rd)
      begin
         rdata_d = 32'h0000_0000;
         if (reg_addr == `HCR_OFS_VERSION)
         begin
            rdata_d[`HCR_VER_PRESENT_BIT] = eeprom_present_flag;
            rdata_d[23:16]                = `HCR_VER_MAJOR;
            rdata_d[7:0]                  = `HCR_VER_MINOR;
         end
         else if (reg_addr == `HCR_OFS_ROM_PORT)
         begin
            rdata_d[`HCR_ROM_CLEAR_BIT] = rom_address_clear;
            rdata_d[`HCR_ROM_FETCH_BIT] = rom_byte_fetch_go;
            rdata_d[`HCR_ROM_DATA_LSB +: 8] = rom_fetched_byte;
            rdata_d[7:0]                = small_rom_offset;
         end
         else if (reg_addr == `HCR_OFS_RETRY)
         begin
            rdata_d[`HCR_RETRY_PHYS_LSB +: `HCR_RETRY_W] = phys_q;
            rdata_d[`HCR_RETRY_RSP_LSB +: `HCR_RETRY_W]  = rsp_q;
            rdata_d[`HCR_RETRY_REQ_LSB +: `HCR_RETRY_W]  = req_q;
         end
         else if (reg_addr == `HCR_OFS_CS_NEW)
         begin
            rdata_d = cs_new_value;
         end
         else if (reg_addr == `HCR_OFS_CS_CMP)
         begin
            rdata_d = cs_cmp_value;
         end
         else if (reg_addr == `HCR_OFS_CS_CTRL)
         begin
            rdata_d[`HCR_CS_DONE_BIT] = compare_swap_complete;
            rdata_d[1:0]              = compare_swap_target;
         end
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         phys_q   <= `HCR_RETRY_RESET;
         rsp_q    <= `HCR_RETRY_RESET;
         req_q    <= `HCR_RETRY_RESET;
         rdata_q  <= 32'h0000_0000;
         rvalid_q <= 1'b0;
      end
      else
      begin
         phys_q   <= phys_d;
         rsp_q    <= rsp_d;
         req_q    <= req_d;
         rdata_q  <= rdata_d;
         rvalid_q <= rvalid_d;
      end
   end

   assign reg_rdata                  = rdata_q;
   assign reg_rvalid                 = rvalid_q;
   assign phys_response_retry_count  = phys_q;
   assign async_response_retry_count = rsp_q;
   assign async_request_retry_count  = req_q;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   // fetched byte tracked for the address-clear check
   logic [7:0] held_byte_q;
   always_ff @(posedge ref_clk)
   begin
      held_byte_q <= rom_fetched_byte;
   end

   a_version_consts: assert property (
      reg_rd && reg_addr == `HCR_OFS_VERSION |=> reg_rdata[23:16] == `HCR_VER_MAJOR
         && reg_rdata[7:0] == `HCR_VER_MINOR)
      else $error("version constants wrong");

   a_version_zero: assert property (
      reg_rd && reg_addr == `HCR_OFS_VERSION |=> reg_rdata[31:25] == 7'h00
         && reg_rdata[15:8] == 8'h00)
      else $error("version reserved bits not zero");

   a_present_bit: assert property (
      reg_rd && reg_addr == `HCR_OFS_VERSION
         |=> reg_rdata[`HCR_VER_PRESENT_BIT] == $past(eeprom_present_flag))
      else $error("present bit mismatch");

   a_clear_done: assert property (
      wr_rom && reg_wdata[`HCR_ROM_CLEAR_BIT] |=> rom_address_clear)
      else $error("address clear not flagged");

   a_clear_keeps: assert property (
      rom_address_clear && !rom_rd_ack |=> rom_fetched_byte == held_byte_q)
      else $error("address clear altered fetched byte");

   a_fetch_ends: assert property (
      rom_byte_fetch_go && u_rom.state_q == ROM_FETCH && rom_rd_ack && !reg_wr
         |=> !rom_byte_fetch_go ##0 rom_fetched_byte == $past(rom_rd_data))
      else $error("fetch did not complete");

   a_rom_zero: assert property (
      reg_rd && reg_addr == `HCR_OFS_ROM_PORT |=> reg_rdata[30:26] == 5'h00
         && !reg_rdata[24] && reg_rdata[15:8] == 8'h00
         && (reg_rdata[7:0] == 8'h00 || reg_rdata[7:0] == `HCR_SMALL_ROM_OFS))
      else $error("rom port reserved bits not zero");

   a_retry_write: assert property (
      wr_retry |=> async_request_retry_count == $past(reg_wdata[3:0])
         && async_response_retry_count == $past(reg_wdata[7:4])
         && phys_response_retry_count == $past(reg_wdata[11:8]))
      else $error("retry write not stored");

   a_retry_upper: assert property (
      reg_rd && reg_addr == `HCR_OFS_RETRY |=> reg_rdata[31:12] == 20'h0_0000)
      else $error("retry upper bits not zero");

   a_done_clear: assert property (
      wr_cs_ctrl && !cs_finished |=> !compare_swap_complete ##0 cs_start)
      else $error("done flag not cleared by write");

   a_done_set: assert property (
      cs_finished |=> compare_swap_complete)
      else $error("done flag not set");

   c_boot_load: cover property (boot_load_valid ##1 !rom_rd_req);
   c_fetch_done: cover property (rom_byte_fetch_go ##[1:20] !rom_byte_fetch_go);
   c_swap_cycle: cover property (cs_start ##[1:20] compare_swap_complete);
   c_retry_set: cover property (wr_retry && reg_wdata[11:0] != 12'h000);

endmodule

// ---- testbench/hcr_rom_model.sv ----
`timescale 1ns/1ps
module hcr_rom_model (
   input  wire logic       ref_clk,
   input  wire logic       rom_rd_req,
   input  wire logic [7:0] rom_rd_addr,
   input  wire logic [3:0] lat,
   output logic            rom_rd_ack,
   output logic [7:0]      rom_rd_data
);
   logic [3:0] cnt = 4'h0;
   initial rom_rd_ack = 1'b0;
   initial rom_rd_data = 8'h00;
   always @(posedge ref_clk)
   begin
      rom_rd_ack <= 1'b0;
      // data is not held after the answer cycle
      rom_rd_data <= ~rom_rd_data;
      if (rom_rd_req && !rom_rd_ack)
      begin
         if (cnt >= lat)
         begin
            rom_rd_ack <= 1'b1;
            rom_rd_data <= rom_rd_addr * 8'h25 + 8'h13;
            cnt <= 4'h0;
         end
         else
            cnt <= cnt + 4'h1;
      end
   end
endmodule

// ---- testbench/hcr_regs_tb.sv ----
`timescale 1ns/1ps
module hcr_regs_tb;
   import hcr_pkg::*;
   localparam int BOOT_N = 8;
   logic           ref_clk = 1'b0;
   logic           rst_n;
   logic [7:0]     reg_addr;
   logic           reg_wr;
   logic           reg_rd;
   logic [31:0]    reg_wdata;
   logic [31:0]    reg_rdata;
   logic           reg_rvalid;
   logic           rom_detect;
   logic           rom_rd_req;
   logic [7:0]     rom_rd_addr;
   logic           rom_rd_ack;
   logic [7:0]     rom_rd_data;
   logic           boot_load_valid;
   logic [7:0]     boot_load_index;
   logic [7:0]     boot_load_data;
   logic [3:0]     phys_response_retry_count;
   logic [3:0]     async_response_retry_count;
   logic [3:0]     async_request_retry_count;
   logic           cs_values_load;
   logic [31:0]    cs_new_value_in;
   logic [31:0]    cs_cmp_value_in;
   logic           cs_finished;
   logic           cs_start;
   hcr_cs_target_t compare_swap_target;
   logic [3:0]     lat;
   integer         seed;
   integer         miscompares;
   integer         cmp_count;
   integer         k;
   logic [31:0]    d;
   logic [31:0]    v;
   logic [31:0]    w;
   logic [7:0]     eb;
   logic [7:0]     ea;

   hcr_regs #(.BOOT_BYTES(BOOT_N)) dut_u (.ref_clk, .rst_n, .reg_addr, .reg_wr, .reg_rd,
      .reg_wdata, .reg_rdata, .reg_rvalid, .rom_detect, .rom_rd_req, .rom_rd_addr,
      .rom_rd_ack, .rom_rd_data, .boot_load_valid, .boot_load_index, .boot_load_data,
      .phys_response_retry_count, .async_response_retry_count, .async_request_retry_count,
      .cs_values_load, .cs_new_value_in, .cs_cmp_value_in, .cs_finished, .cs_start,
      .compare_swap_target);
   hcr_rom_model rom_u (.ref_clk, .rom_rd_req, .rom_rd_addr, .lat, .rom_rd_ack,
      .rom_rd_data);

   always #2.5 ref_clk = ~ref_clk;

   function automatic logic [7:0] rb(input logic [7:0] a);
      return a * 8'h25 + 8'h13;
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         miscompares++;
         $display("ERROR %0t: got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic results;
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] x);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= x;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] x);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      chk(32'(reg_rvalid), 32'h0000_0001);
      x = reg_rdata;
   endtask

   // bounded wait for a self-clearing bit
   task automatic poll(input int b);
      for (int i = 0; i < 100; i++)
      begin
         rd(8'h04, d);
         if (!d[b])
            break;
      end
      chk(32'(d[b]), 32'h0000_0000);
   endtask

   task automatic rst(input logic det);
      @(posedge ref_clk);
      rst_n <= 1'b0;
      rom_detect <= det;
      repeat (4) @(posedge ref_clk);
      rst_n <= 1'b1;
   endtask

   task automatic fetch;
      lat <= 4'($random(seed));
      wr(8'h04, 32'h0200_0000);
      poll(25);
      chk(32'(d[23:16]), 32'(rb(ea)));
      ea++;
   endtask

   initial
   begin
      seed = 35802;
      miscompares = 0;
      cmp_count = 0;
      {rst_n, reg_wr, reg_rd, cs_values_load, cs_finished} = '0;
      {reg_addr, reg_wdata, cs_new_value_in, cs_cmp_value_in} = '0;
      rom_detect = 1'b1;
      lat = 4'h3;
      rst(1'b1);
      for (int i = 0; i < BOOT_N; i++)
      begin
         k = 0;
         do begin @(posedge ref_clk); #1; k++; end while (!boot_load_valid && k < 100);
         chk(32'({boot_load_index, boot_load_data}), 32'({i[7:0], rb(i[7:0])}));
      end
      rd(8'h00, d);
      chk(d, 32'h0101_0010);
      wr(8'h00, $random(seed));
      rd(8'h00, d);
      chk(d, 32'h0101_0010);
      rd(8'h08, d);
      chk(d, 32'h0000_0000);
      for (int i = 0; i < 6; i++)
      begin
         v = (i == 0) ? 32'hffff_ffff : $random(seed);
         wr(8'h08, v);
         rd(8'h08, d);
         chk(d, v & 32'h0000_0fff);
         chk(32'({phys_response_retry_count, async_response_retry_count,
                  async_request_retry_count}), 32'(v[11:0]));
      end
      // rom port used while present here; a fetch with no device follows the second reset
      rd(8'h04, d);
      chk(32'({d[30:26], d[24], d[15:0]}), 32'h0000_0020);
      wr(8'h04, 32'h8000_0000);
      poll(31);
      ea = 8'h00;
      repeat (4) fetch;
      eb = d[23:16];
      wr(8'h04, 32'h8000_0000);
      poll(31);
      chk(32'(d[23:16]), 32'(eb));
      wr(8'h04, 32'h8200_0000);
      poll(25);
      chk(32'(d[23:16]), 32'(rb(8'h00)));
      ea = 8'h01;
      fetch;
      for (int t = 0; t < 4; t++)
      begin
         v = $random(seed);
         @(posedge ref_clk);
         cs_values_load <= 1'b1;
         cs_new_value_in <= v;
         w = $random(seed);
         cs_cmp_value_in <= w;
         @(posedge ref_clk);
         cs_values_load <= 1'b0;
         wr(8'h0c, ~v);
         wr(8'h10, ~w);
         rd(8'h0c, d);
         chk(d, v);
         rd(8'h10, d);
         chk(d, w);
         v = $random(seed);
         v[1:0] = t[1:0];
         wr(8'h14, v);
         #1;
         chk(32'({cs_start, compare_swap_target}), 32'({1'b1, t[1:0]}));
         rd(8'h14, d);
         chk(d, 32'(t[1:0]));
         @(posedge ref_clk);
         cs_finished <= 1'b1;
         @(posedge ref_clk);
         cs_finished <= 1'b0;
         rd(8'h14, d);
         chk(d, {1'b1, 29'h0, t[1:0]});
      end
      rst(1'b0);
      rd(8'h00, d);
      chk(d, 32'h0001_0010);
      rd(8'h04, d);
      eb = d[23:16];
      wr(8'h04, 32'h0200_0000);
      poll(25);
      chk(32'({d[23:16], d[7:0]}), 32'({eb, 8'h00}));
      results;
   end

   // whole run needs well under ten thousand cycles
   initial
   begin
      #100000;
      miscompares++;
      results;
   end
endmodule
